// file: core/ibl_pkg.sv
// shared constants for the instrument bus listener and talker ends
package ibl_pkg;
  localparam int          IBL_LINES      = 16;     // signal lines on the bus
  localparam int          IBL_MAX_INSTR  = 15;     // instruments on one bus
  localparam int          IBL_DW         = 8;      // data lines
  localparam int          IBL_CHAR_W     = 7;      // character code width
  localparam logic [6:0]  IBL_ADDR_RST   = 7'h05;  // default listen address
  localparam logic [2:0]  IBL_GRP_LISTEN = 3'h1;   // command group: listen address
  localparam logic [7:0]  IBL_CMD_UNL    = 8'h3F;  // unlisten
  localparam logic [7:0]  IBL_CMD_GET    = 8'h08;  // group execute trigger
  localparam logic [7:0]  IBL_CMD_DCL    = 8'h14;  // device clear
  localparam logic [7:0]  IBL_CMD_SDC    = 8'h04;  // selected device clear
  localparam int          IBL_SYNC_N     = 3;      // pin synchroniser depth
  localparam int          IBL_FIFO_DEPTH = 2;      // receive buffer entries
  localparam logic [15:0] IBL_PACE_RST   = 16'h0003; // talker pacing value, unused: the talker waits on the handshake alone
endpackage

// file: core/ibl_bus_if.sv
// wired-and bus carrier joining the listener and talker ends
`timescale 1ns/1ps
`default_nettype none
interface ibl_bus_if;
  import ibl_pkg::*;
  logic [IBL_DW-1:0] dio_t_o;   // talker data, active low on the wire
  logic              dio_t_oe;  // talker drives data
  logic              dav_oe;    // talker pulls data valid low
  logic              atn_oe;    // controller pulls attention low
  logic              ifc_oe;    // system controller pulls clear low
  logic              nrfd_oe;   // listener pulls not ready low
  logic              ndac_oe;   // listener pulls not accepted low
  // open-collector wires with pull-ups
  wire [IBL_DW-1:0]  dio_w  = dio_t_oe ? dio_t_o : {IBL_DW{1'b1}};
  wire               dav_w  = ~dav_oe;
  wire               atn_w  = ~atn_oe;
  wire               ifc_w  = ~ifc_oe;
  wire               nrfd_w = ~nrfd_oe;
  wire               ndac_w = ~ndac_oe;
  modport listener (input dio_w, dav_w, atn_w, ifc_w, nrfd_w, ndac_w,
                    output nrfd_oe, ndac_oe);
  modport talker   (input dio_w, nrfd_w, ndac_w,
                    output dio_t_o, dio_t_oe, dav_oe, atn_oe, ifc_oe);
endinterface
`default_nettype wire

// file: core/ibl_listener.sv
// listener end: synchronised three-wire acceptor with addressing and buffer
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - sixteen lines, at most fifteen instruments
// - bytes move eight bits in parallel
// - seven-bit characters, eighth bit optional parity
// - release not-ready when able to take byte
// - talker drives byte after not-ready high
// - on valid: hold not-ready, capture, release accepted
// - talker releases valid after accepted high
// - valid high: pull accepted low, back ready
// - fully interlocked, no fixed rate
// - all control lines active low
// - own listen address in command mode addresses
// - attention false means data bytes
// - attention true means bus commands
// - ignore meaningless commands silently
// - addressed commands only while addressed
// - interface clear drops addressed state
// - only system controller asserts clear
// - only system controller drives remote enable
// - unlisten leaves addressed-listener state
module ibl_listener
  import ibl_pkg::*;
#(
  parameter int DW    = IBL_DW,
  parameter int DEPTH = IBL_FIFO_DEPTH
) (
  input  wire logic          i_clk,       // 125 MHz clock
  input  wire logic          i_rst_n,     // async reset, active low
  ibl_bus_if.listener        bus,         // bus wires
  input  wire logic [6:0]    i_my_addr,   // own listen address
  input  wire logic          i_par_en,    // check odd parity on bit 7
  output logic [DW-1:0]      o_data,      // received data byte
  output logic               o_valid,     // data byte waiting
  input  wire logic          i_ready,     // user takes the byte
  output logic               o_listen,    // addressed as listener
  output logic               o_trigger,   // group trigger pulse
  output logic               o_clear,     // device clear pulse
  output logic               o_par_err    // parity error pulse
);
  typedef enum logic [1:0] {HS_READY, HS_TAKE, HS_ACCEPT} ibl_hs_t;

  // three-stage synchronisers; a change counts once stages two and three agree
  logic [IBL_SYNC_N-1:0] dav_s_reg, atn_s_reg, ifc_s_reg;
  logic [DW-1:0]         dio_s1_reg, dio_s2_reg, dio_s3_reg;
  logic                  dav_reg, atn_reg, ifc_reg;
  ibl_hs_t               hs_reg, hs_next;
  logic                  nrfd_oe_reg, ndac_oe_reg;
  logic                  listen_reg, trig_reg, clr_reg, perr_reg;
  logic [DW-1:0]         mem [DEPTH];
  logic [1:0]            cnt_reg;
  logic                  wp_reg, rp_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dav_s_reg  <= '1;
      atn_s_reg  <= '1;
      ifc_s_reg  <= '1;
      dio_s1_reg <= '1;
      dio_s2_reg <= '1;
      dio_s3_reg <= '1;
      // preload the released level so no false edge follows reset
      dav_reg    <= 1'b1;
      atn_reg    <= 1'b1;
      ifc_reg    <= 1'b1;
    end else begin
      dav_s_reg  <= {dav_s_reg[IBL_SYNC_N-2:0], bus.dav_w};
      atn_s_reg  <= {atn_s_reg[IBL_SYNC_N-2:0], bus.atn_w};
      ifc_s_reg  <= {ifc_s_reg[IBL_SYNC_N-2:0], bus.ifc_w};
      dio_s1_reg <= bus.dio_w;
      dio_s2_reg <= dio_s1_reg;
      dio_s3_reg <= dio_s2_reg;
      if (dav_s_reg[1] == dav_s_reg[2]) dav_reg <= dav_s_reg[2];
      if (atn_s_reg[1] == atn_s_reg[2]) atn_reg <= atn_s_reg[2];
      if (ifc_s_reg[1] == ifc_s_reg[2]) ifc_reg <= ifc_s_reg[2];
    end
  end

  // decoding compares seven bits only; the eighth line may carry parity
  function automatic logic is_code(input logic [DW-1:0] b, input logic [7:0] c);
    return b[6:0] == c[6:0];
  endfunction

  // the talker settles the data lines a cycle before valid falls and valid is voted,
  // so the data word needs no vote of its own; lines are active low
  wire [DW-1:0] rx_byte  = ~dio_s3_reg;
  wire          dav_on   = ~dav_reg;
  wire          cmd_mode = ~atn_reg;
  wire          ifc_on   = ~ifc_reg;
  wire          buf_room = (cnt_reg < 2'(DEPTH));
  // a data byte needs a free buffer slot; commands are always taken
  // an unaddressed listener holds not-ready low on data, which stalls the talker
  wire          can_take = cmd_mode || (listen_reg && buf_room);
  wire          take     = (hs_reg == HS_TAKE);
  wire          is_lad   = is_code(rx_byte, {IBL_GRP_LISTEN, i_my_addr[4:0]});
  wire          is_unl   = is_code(rx_byte, IBL_CMD_UNL);
  wire          is_dcl   = is_code(rx_byte, IBL_CMD_DCL);
  wire          is_get   = is_code(rx_byte, IBL_CMD_GET);
  wire          is_sdc   = is_code(rx_byte, IBL_CMD_SDC);
  // odd parity: a good byte has an odd count of ones across all eight lines
  wire          par_bad  = i_par_en && !(^rx_byte);
  wire          push     = take && !cmd_mode && listen_reg;
  wire          pop      = o_valid && i_ready;
  // occupancy after this edge, shared by the counter and the valid flag
  wire [1:0]    cnt_next = cnt_reg + 2'(push) - 2'(pop);
  // a byte pushed into the slot that becomes the head bypasses the array, so
  // o_valid never rises a cycle ahead of its data
  wire          head_idx = rp_reg ^ pop;
  wire          fwd      = push && (wp_reg == head_idx);
  wire [DW-1:0] head_byte = fwd ? rx_byte : mem[head_idx];

  always_comb begin
    hs_next = hs_reg;
    unique case (hs_reg)
      HS_READY:  if (dav_on && can_take) hs_next = HS_TAKE;
      HS_TAKE:   hs_next = HS_ACCEPT;
      HS_ACCEPT: if (!dav_on) hs_next = HS_READY;
      // the spare two-bit code falls back to the ready step
      default:   hs_next = HS_READY;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hs_reg      <= HS_READY;
      nrfd_oe_reg <= 1'b1;
      ndac_oe_reg <= 1'b1;
    end else begin
      hs_reg      <= hs_next;
      // both lines follow the next state, so they are never released together
      nrfd_oe_reg <= !(hs_next == HS_READY && can_take && !dav_on);
      ndac_oe_reg <= (hs_next != HS_ACCEPT);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      listen_reg <= 1'b0;
      trig_reg   <= 1'b0;
      clr_reg    <= 1'b0;
      perr_reg   <= 1'b0;
    end else begin
      trig_reg <= 1'b0;
      clr_reg  <= 1'b0;
      perr_reg <= push && par_bad;
      // clear outranks any command taken in the same cycle
      if (ifc_on) begin
        listen_reg <= 1'b0;
      end else if (take && cmd_mode) begin
        if (is_lad)
          listen_reg <= 1'b1;
        else if (is_unl)
          listen_reg <= 1'b0;
        else if (is_dcl)
          clr_reg <= 1'b1;
        else if (is_get)
          trig_reg <= listen_reg;
        else if (is_sdc)
          clr_reg <= listen_reg;
        // other codes fall through untouched
      end
    end
  end

  // two-entry receive buffer; a full buffer holds not-ready low
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 2'h0;
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
    end else begin
      if (push) wp_reg <= ~wp_reg;
      if (pop)  rp_reg <= ~rp_reg;
      cnt_reg <= cnt_next;
    end
  end

  // the array has no reset: o_data is undefined until the first byte arrives
  always_ff @(posedge i_clk) begin
    if (push) mem[wp_reg] <= rx_byte;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data    <= '0;
      o_valid   <= 1'b0;
      o_listen  <= 1'b0;
      o_trigger <= 1'b0;
      o_clear   <= 1'b0;
      o_par_err <= 1'b0;
    end else begin
      o_data    <= head_byte;
      o_valid   <= cnt_next != 2'h0;
      o_listen  <= listen_reg;
      o_trigger <= trig_reg;
      o_clear   <= clr_reg;
      o_par_err <= perr_reg;
    end
  end

  assign bus.nrfd_oe = nrfd_oe_reg;
  assign bus.ndac_oe = ndac_oe_reg;
endmodule
`default_nettype wire

// file: core/ibl_talker.sv
// talker and controller end: sources bytes through the three-wire handshake
`timescale 1ns/1ps
`default_nettype none
module ibl_talker
  import ibl_pkg::*;
#(
  parameter int DW = IBL_DW
) (
  input  wire logic          i_clk,     // 125 MHz clock
  input  wire logic          i_rst_n,   // async reset, active low
  ibl_bus_if.talker          bus,       // bus wires
  input  wire logic [DW-1:0] i_data,    // byte to send
  input  wire logic          i_cmd,     // send as command (attention)
  input  wire logic          i_valid,   // byte offered
  output logic               o_ready,   // byte taken this cycle
  input  wire logic          i_ifc,     // request interface clear
  output logic               o_busy     // transfer in progress
);
  typedef enum logic [2:0] {TK_IDLE, TK_WAIT_RDY, TK_SETTLE, TK_WAIT_ACC,
                            TK_WAIT_REL} ibl_tk_t;
  logic [IBL_SYNC_N-1:0] nrfd_s_reg, ndac_s_reg;
  logic                  nrfd_reg, ndac_reg;
  ibl_tk_t               st_reg, st_next;
  logic [DW-1:0]         dat_reg;
  logic                  atn_reg, dav_reg, doe_reg, ifc_reg, rdy_reg, busy_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nrfd_s_reg <= '0;
      ndac_s_reg <= '0;
      nrfd_reg   <= 1'b0;
      ndac_reg   <= 1'b0;
    end else begin
      nrfd_s_reg <= {nrfd_s_reg[IBL_SYNC_N-2:0], bus.nrfd_w};
      ndac_s_reg <= {ndac_s_reg[IBL_SYNC_N-2:0], bus.ndac_w};
      if (nrfd_s_reg[1] == nrfd_s_reg[2]) nrfd_reg <= nrfd_s_reg[2];
      if (ndac_s_reg[1] == ndac_s_reg[2]) ndac_reg <= ndac_s_reg[2];
    end
  end

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      TK_IDLE:     if (i_valid && !i_ifc) st_next = TK_WAIT_RDY;
      TK_WAIT_RDY: if (nrfd_reg) st_next = TK_SETTLE;
      TK_SETTLE:   st_next = TK_WAIT_ACC;
      TK_WAIT_ACC: if (ndac_reg) st_next = TK_WAIT_REL;
      TK_WAIT_REL: if (!ndac_reg) st_next = TK_IDLE;
      default:     st_next = TK_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg  <= TK_IDLE;
      dat_reg <= '0;
      atn_reg <= 1'b0;
      dav_reg <= 1'b0;
      doe_reg <= 1'b0;
      ifc_reg <= 1'b0;
      rdy_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      st_reg  <= st_next;
      ifc_reg <= i_ifc;
      rdy_reg <= (st_reg == TK_IDLE) && (st_next == TK_WAIT_RDY);
      busy_reg <= (st_next != TK_IDLE);
      if (st_reg == TK_IDLE && st_next == TK_WAIT_RDY) begin
        dat_reg <= ~i_data;
        atn_reg <= i_cmd;
      end else if (st_next == TK_IDLE) begin
        atn_reg <= 1'b0;
      end
      doe_reg <= (st_next == TK_SETTLE) || (st_next == TK_WAIT_ACC);
      dav_reg <= (st_next == TK_WAIT_ACC);
    end
  end

  assign o_ready      = rdy_reg;
  assign o_busy       = busy_reg;
  assign bus.dio_t_o  = dat_reg;
  assign bus.dio_t_oe = doe_reg;
  assign bus.dav_oe   = dav_reg;
  assign bus.atn_oe   = atn_reg;
  assign bus.ifc_oe   = ifc_reg;
endmodule
`default_nettype wire

// file: testbench/ibl_asserts.sv
// concurrent checks on the wired-and handshake between listener and talker
`timescale 1ns/1ps
`default_nettype none
module ibl_asserts
  import ibl_pkg::*;
(
  input wire logic              i_clk,    // bus sampling clock
  input wire logic              i_rst_n,  // async reset, active low
  input wire logic [IBL_DW-1:0] dio_w,    // data wires
  input wire logic              dav_w,    // data valid wire
  input wire logic              atn_w,    // attention wire
  input wire logic              nrfd_w,   // not ready wire
  input wire logic              ndac_w    // not accepted wire
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // command bytes are always taken, so the accept must follow within the sync budget
  sequence s_cmd_offer;
    $fell(dav_w) && !atn_w;
  endsequence
  sequence s_accepted;
    ##[1:16] ndac_w;
  endsequence
  chk_valid_after_ready: assert property ($fell(dav_w) |-> $past(nrfd_w))
    else $error("data valid fell while not ready was low");
  chk_data_hold: assert property (!dav_w && $past(!dav_w) |-> $stable(dio_w))
    else $error("data lines moved while data valid was low");
  chk_dav_release: assert property ($rose(dav_w) |-> $past(ndac_w))
    else $error("data valid released before accept");
  chk_nrfd_held: assert property ($rose(ndac_w) |-> !nrfd_w && !dav_w)
    else $error("accept raised without not ready held or valid low");
  chk_cmd_accept: assert property (s_cmd_offer |-> s_accepted)
    else $error("command byte not accepted in time");
  chk_ndac_return: assert property ($rose(dav_w) |-> ##[1:12] !ndac_w)
    else $error("accepted line not pulled low after valid released");
  chk_never_both: assert property (!(nrfd_w && ndac_w))
    else $error("ready and accepted released together");
  chk_ndac_stands: assert property (ndac_w && !dav_w |=> ndac_w)
    else $error("accepted line dropped while valid still low");
endmodule
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench: talker end drives listener end across the bus carrier
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ibl_pkg::*;
  logic i_clk = 1'b0, i_rst_n = 1'b0;
  logic [7:0] t_data = 8'h00, l_data;
  logic t_cmd = 1'b0, t_valid = 1'b0, t_ifc = 1'b0, t_ready, t_busy;
  logic l_ready = 1'b0, l_par_en = 1'b0, l_valid, l_listen, l_trig, l_clr, l_perr;
  int err_total = 0, samples_checked = 0, cyc = 0, trig_n = 0, clr_n = 0, perr_n = 0;
  always #4 i_clk = ~i_clk;
  ibl_bus_if ibus();
  ibl_listener u_ibl_listener (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(ibus),
    .i_my_addr(IBL_ADDR_RST), .i_par_en(l_par_en), .o_data(l_data), .o_valid(l_valid),
    .i_ready(l_ready), .o_listen(l_listen), .o_trigger(l_trig), .o_clear(l_clr),
    .o_par_err(l_perr));
  ibl_talker u_ibl_talker (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(ibus), .i_data(t_data),
    .i_cmd(t_cmd), .i_valid(t_valid), .o_ready(t_ready), .i_ifc(t_ifc), .o_busy(t_busy));
  ibl_asserts u_ibl_asserts (.i_clk(i_clk), .i_rst_n(i_rst_n), .dio_w(ibus.dio_w),
    .dav_w(ibus.dav_w), .atn_w(ibus.atn_w), .nrfd_w(ibus.nrfd_w), .ndac_w(ibus.ndac_w));
  always @(posedge i_clk) begin
    cyc++;
    if (l_trig === 1'b1) trig_n++;
    if (l_clr === 1'b1) clr_n++;
    if (l_perr === 1'b1) perr_n++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // hold the offer until the talker takes it, then let the handshake finish
  task automatic send(input logic [7:0] d, input logic c);
    int n;
    @(negedge i_clk);
    t_data = d; t_cmd = c; t_valid = 1'b1; n = 0;
    do begin @(posedge i_clk); #1; n++; end while (t_ready !== 1'b1 && n < 3000);
    cmp("talker took byte", 8'h01, {7'h00, t_ready});
    @(negedge i_clk) t_valid = 1'b0;
    n = 0;
    while (t_busy !== 1'b0 && n < 3000) begin @(negedge i_clk); n++; end
    cmp("talker done", 8'h00, {7'h00, t_busy});
    repeat (8) @(negedge i_clk);
  endtask
  task automatic pop(input logic [7:0] exp);
    int n;
    n = 0;
    while (l_valid !== 1'b1 && n < 300) begin @(negedge i_clk); n++; end
    cmp("rx valid", 8'h01, {7'h00, l_valid});
    cmp("rx byte", exp, l_data);
    l_ready = 1'b1;
    @(negedge i_clk) l_ready = 1'b0;
  endtask
  task automatic t_address();
    send({IBL_GRP_LISTEN, 5'h06}, 1'b1);
    cmp("listen other addr", 8'h00, {7'h00, l_listen});
    send({IBL_GRP_LISTEN, IBL_ADDR_RST[4:0]}, 1'b1);
    cmp("listen own addr", 8'h01, {7'h00, l_listen});
  endtask
  // two words fill the buffer, the third is held off by not ready until a pop
  task automatic t_buffer();
    send(8'h41, 1'b0);
    send(8'hC2, 1'b0);
    fork send(8'h43, 1'b0); join_none
    repeat (60) @(negedge i_clk);
    cmp("nrfd when full", 8'h00, {7'h00, ibus.nrfd_w});
    pop(8'h41);
    pop(8'hC2);
    pop(8'h43);
    wait fork;
  endtask
  task automatic t_commands();
    send(IBL_CMD_GET, 1'b1);
    cmp("trigger listening", 8'h01, 8'(trig_n));
    send(IBL_CMD_SDC, 1'b1);
    send(8'h15, 1'b1);
    cmp("clear selected", 8'h01, 8'(clr_n));
    cmp("listen after unknown", 8'h01, {7'h00, l_listen});
    send(IBL_CMD_UNL, 1'b1);
    cmp("listen after unlisten", 8'h00, {7'h00, l_listen});
    send(IBL_CMD_GET, 1'b1);
    send(IBL_CMD_SDC, 1'b1);
    cmp("trigger unaddressed", 8'h01, 8'(trig_n));
    send(IBL_CMD_DCL, 1'b1);
    cmp("universal clear", 8'h02, 8'(clr_n));
  endtask
  task automatic t_parity_ifc();
    send({IBL_GRP_LISTEN, IBL_ADDR_RST[4:0]}, 1'b1);
    l_par_en = 1'b1;
    send(8'h01, 1'b0);
    cmp("parity good byte", 8'h00, 8'(perr_n));
    send(8'h03, 1'b0);
    cmp("parity errors", 8'h01, 8'(perr_n));
    pop(8'h01);
    pop(8'h03);
    // clear is a level from the system controller; listen must drop while it stands
    cmp("listen before clear", 8'h01, {7'h00, l_listen});
    @(negedge i_clk) t_ifc = 1'b1;
    repeat (10) @(negedge i_clk);
    cmp("listen after clear", 8'h00, {7'h00, l_listen});
    t_ifc = 1'b0;
    repeat (10) @(negedge i_clk);
  endtask
  initial begin
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (6) @(negedge i_clk);
    t_address();
    t_buffer();
    t_commands();
    t_parity_ifc();
    print_verdict();
  end
endmodule
`default_nettype wire
